/* File: logic/pwr_seq_pkg.sv */
package pwr_seq_pkg;

    // ==========================================================
    // Operating states of the sequencer
    // ==========================================================
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,   // Held in reset
        ST_RUN = 3'h1,     // Normal operation
        ST_SLEEP = 3'h2,   // Core clock gated
        ST_DEEP = 3'h3,    // Core domain clocks and fast sources off
        ST_STANDBY = 3'h4  // Core domain unpowered
    } pm_state_t;

    // ==========================================================
    // Mode select codes written by the processor side
    // ==========================================================
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_DEEP = 2'h2;
    localparam logic [1:0] MODE_STANDBY = 2'h3;

    // ==========================================================
    // System clock source codes
    // ==========================================================
    localparam logic [1:0] CLK_FAST_RC = 2'h0;
    localparam logic [1:0] CLK_FAST_XTAL = 2'h1;
    localparam logic [1:0] CLK_PLL = 2'h2;
    localparam logic [1:0] CLK_RESET_SRC = CLK_FAST_RC;

    // ==========================================================
    // Boot source codes
    // ==========================================================
    localparam logic [1:0] BOOT_MAIN_FLASH = 2'h0;
    localparam logic [1:0] BOOT_SYSTEM_MEM = 2'h1;
    localparam logic [1:0] BOOT_ALT_MEM = 2'h2;
    localparam logic [1:0] BOOT_RESET_SRC = BOOT_MAIN_FLASH;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;      // Clock period
    localparam int RESET_HOLD_NS = 1000;    // Reset stretch after release
    // Least time, rounded up to whole cycles
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 8;               // Hold counter width
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_RESET_VAL = 8'h00;

    // ==========================================================
    // Bus domain clock limits
    // ==========================================================
    localparam int SYS_CLK_MHZ = 100;        // Rate of clk_in
    localparam int AHB_MAX_MHZ = 200;
    localparam int APB1_MAX_MHZ = 50;
    localparam int APB2_MAX_MHZ = 100;
    localparam int DIV_W = 8;                // Divider counter width
    localparam int NUM_DOM = 3;              // AHB, APB1, APB2
    localparam logic [DIV_W-1:0] AHB_MIN_DIV =
        DIV_W'((SYS_CLK_MHZ + AHB_MAX_MHZ - 1) / AHB_MAX_MHZ);
    localparam logic [DIV_W-1:0] APB1_MIN_DIV =
        DIV_W'((SYS_CLK_MHZ + APB1_MAX_MHZ - 1) / APB1_MAX_MHZ);
    localparam logic [DIV_W-1:0] APB2_MIN_DIV =
        DIV_W'((SYS_CLK_MHZ + APB2_MAX_MHZ - 1) / APB2_MAX_MHZ);
    localparam logic [DIV_W-1:0] DIV_RESET_VAL = 8'h00;

    // ==========================================================
    // Synchroniser bank layout
    // ==========================================================
    localparam int SYNC_W = 30;
    localparam int SY_SUPPLY = 0;
    localparam int SY_LVD = 1;
    localparam int SY_EXTERNAL_INTERRUPT_LINES_LO = 2;
    localparam int SY_EXTERNAL_INTERRUPT_LINES_HI = 17;
    localparam int SY_DEEP_HI = 23;          // Last deep wake source
    localparam int SY_EXT_RST = 24;
    localparam int SY_RTC_EVT = 25;
    localparam int SY_WDOG = 26;
    localparam int SY_WAKEUP_PIN = 27;
    localparam int SY_BOOT_LO = 28;
    localparam int SY_BOOT_HI = 29;

endpackage

/* File: logic/sync_bank.sv */
`timescale 1ns/1ps

// Two-flop synchroniser for a bank of asynchronous levels
module sync_bank #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Flop stages
    // ==========================================================
    logic [WIDTH-1:0] meta;  // First stage, read only by second

    // Both stages, per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    meta[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

/* File: logic/power_mode_reset_sequencer.sv */
`timescale 1ns/1ps

// Contract
// - Sleep gates core clock; any event wakes
// - Deep-sleep stops core domain, fast sources
// - Deep-sleep wakes on routed interrupt-line sources
// - Deep-sleep exit selects internal fast RC
// - Standby unpowers domain, regulator and sources
// - Standby exits only on five sources
// - System reset resets core and peripherals
// - Low supply holds device in reset
// - Low voltage detector raises warning interrupt
// - Boot pins sampled at startup choose source
// - Prescalers keep bus domains within limits
module power_mode_reset_sequencer (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic supply_ok_in,          // Supervisor: above threshold
    input wire logic lvd_below_in,          // Supervisor: below warning
    input wire logic [15:0] external_interrupt_lines_lines_in,  // External interrupt lines
    input wire logic rtc_alarm_in,
    input wire logic rtc_tamper_in,
    input wire logic rtc_timestamp_in,
    input wire logic rtc_wakeup_in,
    input wire logic ethernet_wakeup_in,
    input wire logic usb_wakeup_in,
    input wire logic external_reset_pin_b_in,
    input wire logic rtc_event_in,
    input wire logic free_watchdog_reset_in,
    input wire logic wakeup_pin_in,
    input wire logic [1:0] boot_pins_in,    // Bit 0 is boot0
    input wire logic irq_event_in,          // Core side interrupt/event
    input wire logic core_halted_in,        // Core reports it stopped
    input wire logic [1:0] mode_sel_in,     // Requested saving mode
    input wire logic sysclk_wr_in,          // Strobe for sysclk_sel_in
    input wire logic [1:0] sysclk_sel_in,
    input wire logic fast_xtal_req_in,      // Software enables crystal
    input wire logic pll_req_in,            // Software enables PLL
    input wire logic [2:0] ahb_div_code_in, // Divide by 2**code
    input wire logic [2:0] apb1_div_code_in,
    input wire logic [2:0] apb2_div_code_in,
    output logic core_reset_b_out,
    output logic periph_reset_b_out,
    output logic core_clk_en_out,
    output logic periph_clk_en_out,
    output logic internal_fast_rc_en_out,
    output logic external_fast_crystal_en_out,
    output logic pll_en_out,
    output logic regulator_en_out,
    output logic core_domain_power_out,
    output logic [1:0] sysclk_src_out,
    output logic [1:0] boot_src_out,
    output logic lvd_irq_out,
    output logic [2:0] pm_state_out,
    output logic ahb_clk_en_out,
    output logic apb1_clk_en_out,
    output logic apb2_clk_en_out
);

    // ==========================================================
    // Input synchronisation
    // ==========================================================
    logic [pwr_seq_pkg::SYNC_W-1:0] raw;   // Asynchronous inputs
    logic [pwr_seq_pkg::SYNC_W-1:0] sy;    // Synchronised copies

    assign raw = {boot_pins_in, wakeup_pin_in, free_watchdog_reset_in,
                  rtc_event_in, external_reset_pin_b_in, usb_wakeup_in,
                  ethernet_wakeup_in, rtc_wakeup_in, rtc_timestamp_in,
                  rtc_tamper_in, rtc_alarm_in, external_interrupt_lines_lines_in,
                  lvd_below_in, supply_ok_in};

    sync_bank #(
        .WIDTH(pwr_seq_pkg::SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .async_in(raw),
        .sync_out(sy)
    );

    // ==========================================================
    // Decoded conditions
    // ==========================================================
    logic wakeup_pin_d;            // Previous wakeup pin level
    wire supply_ok = sy[pwr_seq_pkg::SY_SUPPLY];
    wire lvd_low = sy[pwr_seq_pkg::SY_LVD];
    wire ext_rst = !sy[pwr_seq_pkg::SY_EXT_RST];
    wire wdog_rst = sy[pwr_seq_pkg::SY_WDOG];
    wire wakeup_pin_rise = sy[pwr_seq_pkg::SY_WAKEUP_PIN] && !wakeup_pin_d;
    wire [1:0] boot_pins = sy[pwr_seq_pkg::SY_BOOT_HI:pwr_seq_pkg::SY_BOOT_LO];
    // Any reset cause, checked in every state
    wire hard_reset = !supply_ok || ext_rst || wdog_rst;
    // Deep-sleep wake: lines, RTC, network, USB and detector output
    wire deep_wake = |sy[pwr_seq_pkg::SY_DEEP_HI:pwr_seq_pkg::SY_EXTERNAL_INTERRUPT_LINES_LO]
                     || lvd_low;
    // Only the RTC event and the pin edge, besides the resets
    wire standby_wake = sy[pwr_seq_pkg::SY_RTC_EVT] || wakeup_pin_rise;
    // Entry only once the core has stopped
    wire enter_req = core_halted_in &&
                     (mode_sel_in != pwr_seq_pkg::MODE_RUN);

    // ==========================================================
    // State and hold counter
    // ==========================================================
    pwr_seq_pkg::pm_state_t state;
    pwr_seq_pkg::pm_state_t next_state;
    logic [pwr_seq_pkg::HOLD_W-1:0] hold_cnt;  // Reset stretch counter
    wire hold_done = (hold_cnt == pwr_seq_pkg::HOLD_LAST);

    // Next state selection
    always_comb begin
        next_state = state;
        if (hard_reset) begin
            // Any reset cause restarts the sequence
            next_state = pwr_seq_pkg::ST_RESET;
        end else begin
            case (state)
                pwr_seq_pkg::ST_RESET: begin
                    if (hold_done) begin
                        next_state = pwr_seq_pkg::ST_RUN;
                    end
                end
                pwr_seq_pkg::ST_RUN: begin
                    if (enter_req) begin
                        case (mode_sel_in)
                            pwr_seq_pkg::MODE_SLEEP: begin
                                next_state = pwr_seq_pkg::ST_SLEEP;
                            end
                            pwr_seq_pkg::MODE_DEEP: begin
                                next_state = pwr_seq_pkg::ST_DEEP;
                            end
                            default: begin
                                next_state = pwr_seq_pkg::ST_STANDBY;
                            end
                        endcase
                    end
                end
                pwr_seq_pkg::ST_SLEEP: begin
                    if (irq_event_in) begin
                        next_state = pwr_seq_pkg::ST_RUN;
                    end
                end
                pwr_seq_pkg::ST_DEEP: begin
                    if (deep_wake) begin
                        next_state = pwr_seq_pkg::ST_RUN;
                    end
                end
                pwr_seq_pkg::ST_STANDBY: begin
                    // Contents lost, so exit goes through reset
                    if (standby_wake) begin
                        next_state = pwr_seq_pkg::ST_RESET;
                    end
                end
                default: begin
                    next_state = pwr_seq_pkg::ST_RESET;
                end
            endcase
        end
    end

    // Next hold count
    wire [pwr_seq_pkg::HOLD_W-1:0] next_hold =
        (next_state != pwr_seq_pkg::ST_RESET || state != next_state) ?
        pwr_seq_pkg::HOLD_RESET_VAL :
        (hold_done ? hold_cnt : hold_cnt + 8'h01);

    // State, counter and edge history
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state <= pwr_seq_pkg::ST_RESET;
            hold_cnt <= pwr_seq_pkg::HOLD_RESET_VAL;
            wakeup_pin_d <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= hard_reset ? pwr_seq_pkg::HOLD_RESET_VAL : next_hold;
            wakeup_pin_d <= sy[pwr_seq_pkg::SY_WAKEUP_PIN];
        end
    end

    // ==========================================================
    // Output decode from the next state
    // ==========================================================
    wire n_rst = (next_state == pwr_seq_pkg::ST_RESET);
    wire n_run = (next_state == pwr_seq_pkg::ST_RUN);
    wire n_sleep = (next_state == pwr_seq_pkg::ST_SLEEP);
    wire n_stby = (next_state == pwr_seq_pkg::ST_STANDBY);
    // Core and peripherals share one reset
    wire next_sys_rst_b = !(n_rst || n_stby);
    // Sleep gates the core only
    wire next_core_clk = n_run;
    wire next_periph_clk = n_run || n_sleep;
    // Crystal and PLL run only in run and sleep; the fast RC also in reset
    wire fast_ok = n_run || n_sleep;
    wire next_xtal = fast_ok && fast_xtal_req_in;
    wire next_pll = fast_ok && pll_req_in;
    // Regulator and domain power drop in standby
    wire next_power = !n_stby;
    wire deep_exit = (state == pwr_seq_pkg::ST_DEEP) && n_run;
    // Sysclk: reset and deep exit force the fast RC
    wire [1:0] next_sysclk =
        (n_rst || deep_exit) ? pwr_seq_pkg::CLK_FAST_RC :
        (sysclk_wr_in && n_run) ? sysclk_sel_in : sysclk_src_out;
    // Boot pin decode: boot0 low is main flash
    wire [1:0] boot_dec =
        !boot_pins[0] ? pwr_seq_pkg::BOOT_MAIN_FLASH :
        !boot_pins[1] ? pwr_seq_pkg::BOOT_SYSTEM_MEM :
        pwr_seq_pkg::BOOT_ALT_MEM;
    wire boot_sample = (state == pwr_seq_pkg::ST_RESET) && n_run;

    // Registered control outputs
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            core_reset_b_out <= 1'b0;
            periph_reset_b_out <= 1'b0;
            core_clk_en_out <= 1'b0;
            periph_clk_en_out <= 1'b0;
            internal_fast_rc_en_out <= 1'b1;
            external_fast_crystal_en_out <= 1'b0;
            pll_en_out <= 1'b0;
            regulator_en_out <= 1'b1;
            core_domain_power_out <= 1'b1;
            pm_state_out <= pwr_seq_pkg::ST_RESET;
        end else begin
            core_reset_b_out <= next_sys_rst_b;
            periph_reset_b_out <= next_sys_rst_b;
            core_clk_en_out <= next_core_clk;
            periph_clk_en_out <= next_periph_clk;
            internal_fast_rc_en_out <= fast_ok || n_rst;
            external_fast_crystal_en_out <= next_xtal;
            pll_en_out <= next_pll;
            regulator_en_out <= next_power;
            core_domain_power_out <= next_power;
            pm_state_out <= next_state;
        end
    end

    // Clock source, boot source and warning interrupt
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sysclk_src_out <= pwr_seq_pkg::CLK_RESET_SRC;
            boot_src_out <= pwr_seq_pkg::BOOT_RESET_SRC;
            lvd_irq_out <= 1'b0;
        end else begin
            sysclk_src_out <= next_sysclk;
            if (boot_sample) begin
                boot_src_out <= boot_dec;
            end
            lvd_irq_out <= lvd_low;
        end
    end

    // ==========================================================
    // Bus domain prescalers
    // ==========================================================
    logic [2:0] div_code [pwr_seq_pkg::NUM_DOM];
    logic [pwr_seq_pkg::DIV_W-1:0] min_div [pwr_seq_pkg::NUM_DOM];
    logic [pwr_seq_pkg::DIV_W-1:0] div_cnt [pwr_seq_pkg::NUM_DOM];
    logic [pwr_seq_pkg::NUM_DOM-1:0] dom_en;  // Enable pulses

    assign div_code[0] = ahb_div_code_in;
    assign div_code[1] = apb1_div_code_in;
    assign div_code[2] = apb2_div_code_in;
    assign min_div[0] = pwr_seq_pkg::AHB_MIN_DIV;
    assign min_div[1] = pwr_seq_pkg::APB1_MIN_DIV;
    assign min_div[2] = pwr_seq_pkg::APB2_MIN_DIV;
    assign ahb_clk_en_out = dom_en[0];
    assign apb1_clk_en_out = dom_en[1];
    assign apb2_clk_en_out = dom_en[2];

    genvar d;
    generate
        for (d = 0; d < pwr_seq_pkg::NUM_DOM; d++) begin : g_dom
            // Requested ratio, raised to the domain's least ratio
            wire [pwr_seq_pkg::DIV_W-1:0] req_div = 8'h01 << div_code[d];
            wire [pwr_seq_pkg::DIV_W-1:0] eff_div =
                (req_div < min_div[d]) ? min_div[d] : req_div;
            wire wrap = (div_cnt[d] == pwr_seq_pkg::DIV_RESET_VAL);
            // Down counter, pulse on wrap while peripherals clock
            always_ff @(posedge clk_in) begin
                if (!rst_b_in || !next_periph_clk) begin
                    div_cnt[d] <= pwr_seq_pkg::DIV_RESET_VAL;
                    dom_en[d] <= 1'b0;
                end else begin
                    div_cnt[d] <= wrap ? eff_div - 8'h01 : div_cnt[d] - 8'h01;
                    dom_en[d] <= wrap;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_in_deep;
        state == pwr_seq_pkg::ST_DEEP && !hard_reset;
    endsequence

    sequence s_apb1_pulse;
        apb1_clk_en_out ##1 !apb1_clk_en_out;
    endsequence

    AST_SLEEP_GATE: assert property (
        state == pwr_seq_pkg::ST_SLEEP |->
        !core_clk_en_out && periph_clk_en_out)
        else $error("sleep clocks wrong");

    AST_SLEEP_WAKE: assert property (
        state == pwr_seq_pkg::ST_SLEEP && irq_event_in && !hard_reset
        |=> state == pwr_seq_pkg::ST_RUN && core_clk_en_out)
        else $error("sleep did not wake");

    AST_DEEP_OFF: assert property (
        state == pwr_seq_pkg::ST_DEEP |-> !periph_clk_en_out &&
        !internal_fast_rc_en_out && !external_fast_crystal_en_out &&
        !pll_en_out && !core_clk_en_out && core_reset_b_out)
        else $error("deep-sleep sources not off");

    AST_DEEP_WAKE: assert property (
        s_in_deep ##0 deep_wake |=> state == pwr_seq_pkg::ST_RUN)
        else $error("deep-sleep did not wake");

    AST_DEEP_EXIT_CLK: assert property (
        s_in_deep ##1 state == pwr_seq_pkg::ST_RUN |->
        sysclk_src_out == pwr_seq_pkg::CLK_FAST_RC)
        else $error("deep exit clock not fast RC");

    AST_STANDBY_OFF: assert property (
        state == pwr_seq_pkg::ST_STANDBY |-> !regulator_en_out &&
        !core_domain_power_out && !internal_fast_rc_en_out &&
        !pll_en_out && !external_fast_crystal_en_out && !core_reset_b_out)
        else $error("standby power not removed");

    AST_STANDBY_STAY: assert property (
        state == pwr_seq_pkg::ST_STANDBY && !hard_reset && !standby_wake
        |=> state == pwr_seq_pkg::ST_STANDBY)
        else $error("standby left without source");

    AST_RESET_BOTH: assert property (
        hard_reset |=> !core_reset_b_out && !periph_reset_b_out
        && !core_clk_en_out)
        else $error("reset did not reach core and peripherals");

    AST_POR_HOLD: assert property (
        !supply_ok |=> state == pwr_seq_pkg::ST_RESET ##1
        !core_reset_b_out)
        else $error("low supply not held in reset");

    AST_LVD_IRQ: assert property (
        lvd_low |=> lvd_irq_out)
        else $error("low voltage warning missing");

    AST_BOOT_STABLE: assert property (
        state != pwr_seq_pkg::ST_RESET &&
        $past(state) != pwr_seq_pkg::ST_RESET |-> $stable(boot_src_out))
        else $error("boot source changed after startup");

    AST_APB1_LIMIT: assert property (
        apb1_clk_en_out |-> s_apb1_pulse)
        else $error("first APB domain above its limit");

    AST_ENTRY_HALT: assert property (
        state == pwr_seq_pkg::ST_RUN && !core_halted_in |=>
        state == pwr_seq_pkg::ST_RUN || state == pwr_seq_pkg::ST_RESET)
        else $error("mode entered before core halted");

endmodule

/* File: bench/core_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Core side: selects a saving mode, then reports it stopped
// ==========================================================
module core_model (
    input wire logic clk_in,
    input wire logic go_in,          // Ask for a saving mode
    input wire logic [1:0] mode_in,  // Mode to ask for
    output logic [1:0] mode_sel_out,
    output logic halted_out
);
    // Mode select first, halt only once the select is in place
    always_ff @(posedge clk_in) begin
        mode_sel_out <= go_in ? mode_in : pwr_seq_pkg::MODE_RUN;
        halted_out <= go_in && (mode_sel_out == mode_in);
    end
endmodule

/* File: bench/power_mode_reset_sequencer_tb_top.sv */
`timescale 1ns/1ps

module power_mode_reset_sequencer_tb_top;
    typedef struct {
        logic [1:0] mode;  // Requested mode
        logic [2:0] st;    // State it should give
        int wk;            // Wake source index
        logic [5:0] en;    // Core, periph, RC, crystal, PLL, regulator
    } row_t;
    logic clk_in, rst_b_in, supply_ok, lvd_below, pin_b, wakeup_pin_pin;
    logic go, halted, sysclk_wr, req;
    logic [1:0] sb_src;  // RTC event, watchdog reset
    logic [2:0] div_code;  // Shared prescaler code
    logic [1:0] mode, mode_sel, boot_pins, sysclk_sel, sysclk_src, boot_src;
    logic [7:0] wk_v;  // Wake lines, bit 7 is the core event
    logic core_rst_b, periph_rst_b, core_clk, periph_clk, rc_en, xtal_en;
    logic pll_en, reg_en, pwr, lvd_irq, ahb, apb1, apb2;
    logic [2:0] state;
    row_t rows [8];
    int n_mismatch, compares, cnt, cnt_ahb, cnt_apb2;
    int per_ahb, per_apb1, per_apb2;  // Expected pulse periods
    // Gating outputs in row order
    wire [5:0] gates = {core_clk, periph_clk, rc_en, xtal_en, pll_en, reg_en};

    core_model core (.clk_in(clk_in), .go_in(go), .mode_in(mode),
        .mode_sel_out(mode_sel), .halted_out(halted));

    power_mode_reset_sequencer dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .supply_ok_in(supply_ok), .lvd_below_in(lvd_below),
        .external_interrupt_lines_lines_in({wk_v[0], 15'h0000}), .rtc_alarm_in(wk_v[1]),
        .rtc_tamper_in(wk_v[2]), .rtc_timestamp_in(wk_v[3]),
        .rtc_wakeup_in(wk_v[4]), .ethernet_wakeup_in(wk_v[5]),
        .usb_wakeup_in(wk_v[6]), .external_reset_pin_b_in(pin_b),
        .rtc_event_in(sb_src[0]), .free_watchdog_reset_in(sb_src[1]),
        .wakeup_pin_in(wakeup_pin_pin), .boot_pins_in(boot_pins),
        .irq_event_in(wk_v[7]), .core_halted_in(halted),
        .mode_sel_in(mode_sel), .sysclk_wr_in(sysclk_wr),
        .sysclk_sel_in(sysclk_sel), .fast_xtal_req_in(req),
        .pll_req_in(req), .ahb_div_code_in(div_code),
        .apb1_div_code_in(div_code), .apb2_div_code_in(div_code),
        .core_reset_b_out(core_rst_b),
        .periph_reset_b_out(periph_rst_b), .core_clk_en_out(core_clk),
        .periph_clk_en_out(periph_clk), .internal_fast_rc_en_out(rc_en),
        .external_fast_crystal_en_out(xtal_en), .pll_en_out(pll_en),
        .regulator_en_out(reg_en), .core_domain_power_out(pwr),
        .sysclk_src_out(sysclk_src), .boot_src_out(boot_src),
        .lvd_irq_out(lvd_irq), .pm_state_out(state), .ahb_clk_en_out(ahb),
        .apb1_clk_en_out(apb1), .apb2_clk_en_out(apb2));

    // ======================================================
    // Helpers
    // ======================================================
    // Clock at 100 MHz
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Move just after the rising edge
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    // Compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for a state
    task automatic wait_state(input logic [2:0] st, input int lim);
        for (int i = 0; i < lim && state !== st; i++) step();
        check(state, st);
    endtask
    // Counts and verdict
    task automatic end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        {rst_b_in, supply_ok, lvd_below, pin_b, wakeup_pin_pin} = 5'h0a;
        {go, sysclk_wr, req, wk_v, mode, sb_src} = 15'h0000;
        {boot_pins, sysclk_sel} = 4'h5;
        div_code = 3'h0;
        rows[0] = '{pwr_seq_pkg::MODE_SLEEP, pwr_seq_pkg::ST_SLEEP, 7, 6'h1f};
        for (int i = 0; i < 7; i++) begin
            rows[i + 1] = '{pwr_seq_pkg::MODE_DEEP, pwr_seq_pkg::ST_DEEP, i,
                6'h01};
        end
        repeat (12) step();
        rst_b_in = 1'b1;
        req = 1'b1;
        wait_state(pwr_seq_pkg::ST_RUN, 150);
        check(boot_src, pwr_seq_pkg::BOOT_SYSTEM_MEM);
        // Table rows: enter, check gating, wake, check clock source
        foreach (rows[r]) begin
            sysclk_sel = pwr_seq_pkg::CLK_PLL;
            sysclk_wr = 1'b1;
            step();
            sysclk_wr = 1'b0;
            mode = rows[r].mode;
            go = 1'b1;
            wait_state(rows[r].st, 10);
            go = 1'b0;
            check(gates, rows[r].en);
            wk_v[rows[r].wk] = 1'b1;
            wait_state(pwr_seq_pkg::ST_RUN, 10);
            wk_v = 8'h00;
            check(sysclk_src, r ? pwr_seq_pkg::CLK_FAST_RC :
                pwr_seq_pkg::CLK_PLL);
        end
        // Standby ignores interrupt lines, leaves on the wake pin
        mode = pwr_seq_pkg::MODE_STANDBY;
        go = 1'b1;
        wait_state(pwr_seq_pkg::ST_STANDBY, 10);
        go = 1'b0;
        check({reg_en, pwr, rc_en, xtal_en, pll_en}, 5'h00);
        wk_v = 8'hff;
        repeat (10) step();
        check(state, pwr_seq_pkg::ST_STANDBY);
        wk_v = 8'h00;
        wakeup_pin_pin = 1'b1;
        wait_state(pwr_seq_pkg::ST_RESET, 10);
        wakeup_pin_pin = 1'b0;
        boot_pins = 2'h3;
        wait_state(pwr_seq_pkg::ST_RUN, 150);
        check(boot_src, pwr_seq_pkg::BOOT_ALT_MEM);
        // Reset pin resets core and peripherals together
        pin_b = 1'b0;
        wait_state(pwr_seq_pkg::ST_RESET, 10);
        check({core_rst_b, periph_rst_b}, 2'h0);
        pin_b = 1'b1;
        boot_pins = 2'h0;
        wait_state(pwr_seq_pkg::ST_RUN, 150);
        check(boot_src, pwr_seq_pkg::BOOT_MAIN_FLASH);
        // Standby also leaves on the RTC event and the watchdog reset
        mode = pwr_seq_pkg::MODE_STANDBY;
        for (int s = 0; s < 2; s++) begin
            go = 1'b1;
            wait_state(pwr_seq_pkg::ST_STANDBY, 10);
            go = 1'b0;
            sb_src[s] = 1'b1;
            wait_state(pwr_seq_pkg::ST_RESET, 10);
            sb_src = 2'h0;
            wait_state(pwr_seq_pkg::ST_RUN, 150);
        end
        // Low supply holds reset for as long as it lasts
        supply_ok = 1'b0;
        wait_state(pwr_seq_pkg::ST_RESET, 10);
        repeat (150) step();
        check({core_rst_b, periph_rst_b, state}, 5'h00);
        supply_ok = 1'b1;
        wait_state(pwr_seq_pkg::ST_RUN, 150);
        // Low-voltage warning follows the detector
        lvd_below = 1'b1;
        repeat (4) step();
        check(lvd_irq, 1'b1);
        lvd_below = 1'b0;
        repeat (4) step();
        check(lvd_irq, 1'b0);
        // Bus domains: least ratios at code 0, divide by four at code 2
        for (int p = 0; p < 2; p++) begin
            div_code = 3'(2 * p);
            per_ahb = p ? 4 : int'(pwr_seq_pkg::AHB_MIN_DIV);
            per_apb1 = p ? 4 : int'(pwr_seq_pkg::APB1_MIN_DIV);
            per_apb2 = p ? 4 : int'(pwr_seq_pkg::APB2_MIN_DIV);
            repeat (4) step();
            cnt = 0;
            cnt_ahb = 0;
            cnt_apb2 = 0;
            repeat (20) begin
                step();
                cnt += int'(apb1);
                cnt_ahb += int'(ahb);
                cnt_apb2 += int'(apb2);
            end
            check(8'(cnt), 8'(20 / per_apb1));
            check(8'(cnt_ahb), 8'(20 / per_ahb));
            check(8'(cnt_apb2), 8'(20 / per_apb2));
        end
        end_sim();
    end
endmodule
